// File: cms_pkg.sv
// Constants, register map and carriers for the CAN mode and interrupt status
// block. Assumes an AXI4-Lite slave with 32-bit data and one word per register.
package cms_pkg;

    localparam logic [4:0] CMS_OFS_CONTROL  = 5'h00;
    localparam logic [4:0] CMS_OFS_STATUS   = 5'h04;
    localparam logic [4:0] CMS_OFS_ENH_CTRL = 5'h08;
    localparam logic [4:0] CMS_OFS_EVENTS   = 5'h0c;

    localparam logic [2:0] CMS_REQ_RESET  = 3'h4;
    localparam logic [2:0] CMS_MODE_CONFIG = 3'h4;
    localparam logic [2:0] CMS_MODE_LISTEN = 3'h3;
    localparam logic [2:0] CMS_MODE_LOOP   = 3'h2;
    localparam logic [2:0] CMS_MODE_DIS    = 3'h1;
    localparam logic [2:0] CMS_MODE_NORMAL = 3'h0;

    localparam logic [1:0] CMS_MDSEL_LEGACY = 2'h0;
    localparam logic [1:0] CMS_MDSEL_ENH    = 2'h1;
    localparam logic [1:0] CMS_MDSEL_FIFO   = 2'h2;

    localparam int CMS_REQ_LSB  = 5;
    localparam int CMS_ABT_BIT  = 4;
    localparam int CMS_WIN_LSB  = 1;
    localparam int CMS_MDS_LSB  = 6;
    localparam logic [4:0] CMS_EWIN_RESET = 5'h10;

    localparam logic [4:0] CMS_IC_NONE   = 5'h00;
    localparam logic [4:0] CMS_IC_ERR    = 5'h02;
    localparam logic [4:0] CMS_IC_TX2    = 5'h04;
    localparam logic [4:0] CMS_IC_TX1    = 5'h06;
    localparam logic [4:0] CMS_IC_TX0    = 5'h08;
    localparam logic [4:0] CMS_IC_RX1_L  = 5'h0a;
    localparam logic [4:0] CMS_IC_RX0_L  = 5'h0c;
    localparam logic [4:0] CMS_IC_WAKE_L = 5'h0e;
    localparam logic [4:0] CMS_IC_WAKE_E = 5'h0e;
    localparam logic [4:0] CMS_IC_RX0_E  = 5'h10;
    localparam logic [4:0] CMS_IC_RX1_E  = 5'h11;
    localparam logic [4:0] CMS_IC_PB0    = 5'h12;

    localparam logic [1:0] CMS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CMS_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       err;
        logic       wake;
        logic [2:0] tx;
        logic [1:0] rx;
        logic [5:0] pb;
        logic [5:0] pb_is_rx;
    } cms_irq_s;

    typedef struct packed {
        logic [1:0] mdsel;
        logic [4:0] ewin;
    } cms_enh_s;

endpackage

// File: cms_irq_encode.sv
// Priority encoder for the interrupt code. Pure combinational; the caller
// registers the result.
`timescale 1ns/100ps
`default_nettype none
module cms_irq_encode
    import cms_pkg::*;
(
    input  wire cms_pkg::cms_irq_s irq,
    input  wire logic [1:0]        mdsel,
    output logic [4:0]             code
);
    logic [4:0] pb_code;

    // Lowest programmable buffer wins among themselves
    always_comb begin
        pb_code = CMS_IC_NONE;
        for (int i = 5; i >= 0; i--) begin
            if (irq.pb[i]) begin
                if (mdsel == CMS_MDSEL_FIFO && irq.pb_is_rx[i]) begin
                    pb_code = CMS_IC_RX0_E;
                end else begin
                    pb_code = CMS_IC_PB0 + 5'(i);
                end
            end
        end
    end

    // Error first, then transmit, receive, programmable buffers (not in legacy), wake-up; zero when idle
    always_comb begin
        code = CMS_IC_NONE;
        if (mdsel == CMS_MDSEL_LEGACY) begin
            if (irq.err)            code = CMS_IC_ERR;
            else if (irq.tx[2])     code = CMS_IC_TX2;
            else if (irq.tx[1])     code = CMS_IC_TX1;
            else if (irq.tx[0])     code = CMS_IC_TX0;
            else if (irq.rx[0])     code = CMS_IC_RX0_L;
            else if (irq.rx[1])     code = CMS_IC_RX1_L;
            else if (irq.wake)      code = CMS_IC_WAKE_L;
        end else begin
            if (irq.err)            code = CMS_IC_ERR;
            else if (irq.tx[2])     code = CMS_IC_TX2;
            else if (irq.tx[1])     code = CMS_IC_TX1;
            else if (irq.tx[0])     code = CMS_IC_TX0;
            else if (irq.rx[0])     code = CMS_IC_RX0_E;
            else if (irq.rx[1])     code = (mdsel == CMS_MDSEL_FIFO) ?
                                           CMS_IC_RX0_E : CMS_IC_RX1_E;
            else if (|irq.pb)       code = pb_code;
            else if (irq.wake)      code = CMS_IC_WAKE_E;
        end
    end
endmodule // cms_irq_encode
`default_nettype wire

// File: cms_mode_ctrl.sv
// Operating-mode sequencer: turns the mode request into the reported mode.
// Assumes bus_idle is already synchronised to aclk.
`timescale 1ns/100ps
`default_nettype none
module cms_mode_ctrl
    import cms_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] mode_request,
    input  wire logic       bus_idle,
    output logic [2:0]      mode_status
);
    logic [2:0] mode_q;
    logic [2:0] mode_d;

    always_comb begin
        mode_d = mode_q;
        if (mode_request[2]) begin
            // Leaving the bus mid-frame would corrupt it for other nodes
            if (bus_idle) mode_d = CMS_MODE_CONFIG;
        end else begin
            mode_d = mode_request;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) mode_q <= CMS_MODE_CONFIG;
        else          mode_q <= mode_d;
    end

    assign mode_status = mode_q;
endmodule // cms_mode_ctrl
`default_nettype wire

// File: cms_top.sv
// Top of the CAN mode and interrupt status block: AXI4-Lite register slave,
// mode request and report, abort-all, window select and interrupt code.
// Assumes the protocol engine is on aclk; bus_idle comes from a pin domain.
`timescale 1ns/100ps
`default_nettype none
module cms_top
    import cms_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [4:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [4:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              bus_idle,
    input  wire cms_pkg::cms_irq_s irq_pending,
    input  wire logic [2:0]        tx_pending,
    input  wire logic [2:0]        fifo_read_pointer,
    output logic [2:0]             mode_status,
    output logic                   abort_all_tx,
    output logic [2:0]             window_select,
    output logic [1:0]             controller_mode_select,
    output logic [4:0]             enhanced_window_select
);
    // The pointer field is three bits wide, so only eight entries fit
    if (FIFO_DEPTH != 8) begin : g_depth_check
        $error("cms_top: FIFO_DEPTH must be 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus idle synchroniser
    logic idle_s1_q;
    logic idle_s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_s1_q <= 1'b0;
            idle_s2_q <= 1'b0;
        end else begin
            idle_s1_q <= bus_idle;
            idle_s2_q <= idle_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [2:0] req_q, req_d;
    logic       abt_q, abt_d;
    logic [2:0] win_q, win_d;
    cms_enh_s   enh_q, enh_d;
    logic [4:0] code_q;
    logic [4:0] code_c;
    logic [2:0] mode_c;
    logic [2:0] mode_q;

    // AXI write channel
    logic        aw_q, aw_d;
    logic        w_q, w_d;
    logic [4:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bv_q, bv_d;
    logic [1:0]  br_q, br_d;
    // AXI read channel
    logic        rv_q, rv_d;
    logic [31:0] rd_q, rd_d;
    logic [1:0]  rr_q, rr_d;

    cms_mode_ctrl u_mode (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .mode_request (req_q),
        .bus_idle     (idle_s2_q),
        .mode_status  (mode_c)
    );

    cms_irq_encode u_enc (
        .irq   (irq_pending),
        .mdsel (enh_q.mdsel),
        .code  (code_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Readback images
    logic [7:0] ctrl_img;
    logic [7:0] stat_img;
    always_comb begin
        ctrl_img = {req_q, abt_q, 4'h0};
        unique case (enh_q.mdsel)
            CMS_MDSEL_LEGACY: ctrl_img[3:1] = win_q;
            CMS_MDSEL_FIFO: begin
                ctrl_img[3:0] = {1'b0, fifo_read_pointer};
            end
            default:          ctrl_img[3:0] = 4'h0;
        endcase
        stat_img = {mode_q, code_q};
        if (enh_q.mdsel == CMS_MDSEL_LEGACY) begin
            stat_img[4] = 1'b0;
            stat_img[0] = 1'b0;
        end
    end

    logic wr_go;
    assign wr_go = aw_q && w_q && !bv_q;

    always_comb begin
        req_d = req_q;
        win_d = win_q;
        enh_d = enh_q;
        // Self-clears once nothing is left pending
        abt_d = abt_q && (|tx_pending);
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q && !s_axi_bready;
        br_d = br_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = CMS_RESP_OKAY;
            unique case (awa_q)
                CMS_OFS_CONTROL: if (ws_q[0]) begin
                    req_d = wd_q[CMS_REQ_LSB +: 3];
                    if (wd_q[CMS_ABT_BIT]) abt_d = 1'b1;
                    win_d = wd_q[CMS_WIN_LSB +: 3];
                end
                CMS_OFS_ENH_CTRL: if (ws_q[0]) begin
                    enh_d.ewin = wd_q[4:0];
                    // Reserved 11 is refused
                    if (mode_q == CMS_MODE_CONFIG &&
                        wd_q[CMS_MDS_LSB +: 2] != 2'h3) begin
                        enh_d.mdsel = wd_q[CMS_MDS_LSB +: 2];
                    end
                end
                CMS_OFS_STATUS, CMS_OFS_EVENTS: ;
                default: br_d = CMS_RESP_SLVERR;
            endcase
        end
    end

    always_comb begin
        rv_d = rv_q && !s_axi_rready;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = CMS_RESP_OKAY;
            rd_d = 32'h0;
            unique case (s_axi_araddr)
                CMS_OFS_CONTROL:  rd_d[7:0] = ctrl_img;
                CMS_OFS_STATUS:   rd_d[7:0] = stat_img;
                CMS_OFS_ENH_CTRL: rd_d[7:0] = {enh_q.mdsel, 1'b0,
                                               enh_q.ewin};
                CMS_OFS_EVENTS:   rd_d[7:0] = {3'h0, tx_pending,
                                               idle_s2_q, abt_q};
                default:          rr_d = CMS_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q  <= CMS_REQ_RESET;
            abt_q  <= 1'b0;
            win_q  <= 3'h0;
            enh_q  <= '{mdsel: CMS_MDSEL_LEGACY, ewin: CMS_EWIN_RESET};
            code_q <= CMS_IC_NONE;
            mode_q <= CMS_MODE_CONFIG;
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            awa_q  <= 5'h0;
            wd_q   <= 32'h0;
            ws_q   <= 4'h0;
            bv_q   <= 1'b0;
            br_q   <= 2'h0;
            rv_q   <= 1'b0;
            rd_q   <= 32'h0;
            rr_q   <= 2'h0;
        end else begin
            req_q  <= req_d;
            abt_q  <= abt_d;
            win_q  <= win_d;
            enh_q  <= enh_d;
            code_q <= code_c;
            mode_q <= mode_c;
            aw_q   <= aw_d;
            w_q    <= w_d;
            awa_q  <= awa_d;
            wd_q   <= wd_d;
            ws_q   <= ws_d;
            bv_q   <= bv_d;
            br_q   <= br_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            rr_q   <= rr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = !aw_q;
    assign s_axi_wready  = !w_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign mode_status   = mode_q;
    assign abort_all_tx  = abt_q;
    // Window value maps: 101 RX1, 100 TX0, 011 TX1, 010 TX2, rest RX0
    assign window_select = win_q;
    assign controller_mode_select = enh_q.mdsel;
    assign enhanced_window_select = enh_q.ewin;
endmodule // cms_top
`default_nettype wire

// File: cms_props.sv
// Checker for the CAN mode and interrupt status block.
// Sees only top-level ports; one clock aclk, synchronous aresetn.
`timescale 1ns/100ps
`default_nettype none
module cms_props
    import cms_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        bus_idle,
    input wire logic [2:0]  tx_pending,
    input wire logic [2:0]  mode_status,
    input wire logic        abort_all_tx,
    input wire logic [1:0]  controller_mode_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    property p_reset_cfg;
        $rose(aresetn) |-> mode_status == 3'h4;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("Mode status not configuration after reset");
    property p_legal;
        !(mode_status inside {3'h5, 3'h6, 3'h7});
    endproperty
    a_legal: assert property (p_legal)
        else $error("Reserved mode status reported");
    // Two sync stages, sequencer and status register: four quiet samples
    property p_cfg_idle;
        $past(mode_status) != 3'h4 && !$past(bus_idle) && !$past(bus_idle, 2)
            && !$past(bus_idle, 3) && !$past(bus_idle, 4)
            |-> mode_status != 3'h4;
    endproperty
    a_cfg_idle: assert property (p_cfg_idle)
        else $error("Configuration entered while bus active");
    property p_abort_hold;
        abort_all_tx && tx_pending != 3'h0 |=> abort_all_tx;
    endproperty
    a_abort_hold: assert property (p_abort_hold)
        else $error("Abort released with transmissions pending");
    property p_abort_clear;
        abort_all_tx && tx_pending == 3'h0 |-> ##[1:2] !abort_all_tx;
    endproperty
    a_abort_clear: assert property (p_abort_clear)
        else $error("Abort did not clear itself");
    property p_mdsel;
        $changed(controller_mode_select) |-> $past(mode_status) == 3'h4;
    endproperty
    a_mdsel: assert property (p_mdsel)
        else $error("Controller mode changed outside configuration");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("Write response dropped before taken");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("Read data dropped before taken");
    c_cfg: cover property ($rose(mode_status == 3'h4));
    c_abort: cover property ($fell(abort_all_tx));
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // cms_props
bind cms_top cms_props u_props (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bus_idle,
    .tx_pending, .mode_status, .abort_all_tx, .controller_mode_select);
`default_nettype wire

// File: cms_engine_model.sv
// Far-side model: protocol engine and bus as the block sees them.
// Assumes the block's clock and synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module cms_engine_model
    import cms_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              frame_busy,
    input  wire cms_pkg::cms_irq_s irq_req,
    input  wire logic [2:0]        tx_load,
    input  wire logic              abort_all_tx,
    output logic                   bus_idle,
    output cms_pkg::cms_irq_s      irq_pending,
    output logic [2:0]             tx_pending
);
    logic [2:0] gap_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q       <= 3'h0;
            bus_idle    <= 1'h0;
            irq_pending <= '0;
            tx_pending  <= 3'h0;
        end else begin
            irq_pending <= irq_req;
            // Idle only after a full quiet intermission
            gap_q    <= frame_busy ? 3'h0 : gap_q + {2'h0, gap_q != 3'h7};
            bus_idle <= !frame_busy && gap_q == 3'h7;
            // A frame on the wire cannot be pulled back mid-way
            if (abort_all_tx && !frame_busy)
                tx_pending <= tx_pending & (tx_pending - 3'h1);
            else
                tx_pending <= tx_pending | tx_load;
        end
    end
endmodule // cms_engine_model
`default_nettype wire

// File: testbench.sv
// Testbench: AXI4-Lite register traffic plus the far-side model.
// Assumes cms_pkg, cms_top, the model and the checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import cms_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0, frame_busy = 1'h0;
    logic [4:0]  s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    cms_irq_s    irq_req = '0;
    logic [2:0]  tx_load = 3'h0, fifo_read_pointer = 3'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, bus_idle, abort_all_tx;
    logic [1:0]  s_axi_bresp, s_axi_rresp, controller_mode_select, rs;
    logic [31:0] s_axi_rdata, rd;
    cms_irq_s    irq_pending;
    logic [2:0]  tx_pending, mode_status, window_select;
    logic [4:0]  enhanced_window_select;
    int          mismatches = 0, n_compared = 0;
    // Legacy 0-9, enhanced 10-18, FIFO 19-21
    logic [18:0] src [22] = '{19'h0, 19'h40000, 19'h10000, 19'h08000,
        19'h04000, 19'h02000, 19'h01000, 19'h20000, 19'h44000, 19'h05000,
        19'h01000, 19'h02000, 19'h20000, 19'h00040, 19'h00800, 19'h10000,
        19'h40000, 19'h01040, 19'h20040, 19'h02000, 19'h00104, 19'h00100};
    logic [4:0]  code [22] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a,
        5'h0c, 5'h0e, 5'h02, 5'h08, 5'h10, 5'h11, 5'h0e, 5'h12, 5'h17,
        5'h04, 5'h02, 5'h10, 5'h12, 5'h10, 5'h10, 5'h14};

    always #4 aclk = ~aclk;

    cms_top #(.FIFO_DEPTH(8)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_idle,
        .irq_pending, .tx_pending, .fifo_read_pointer, .mode_status,
        .abort_all_tx, .window_select, .controller_mode_select,
        .enhanced_window_select);
    cms_engine_model u_far (.aclk, .aresetn, .frame_busy, .irq_req, .tx_load,
        .abort_all_tx, .bus_idle, .irq_pending, .tx_pending);
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note(input string nm);
        $display("Test %s finished", nm);
    endtask
    // Each channel is released at the edge that samples its ready
    task automatic wait_resp(input logic wr);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 64);
        if (n >= 64) begin
            mismatches++;
            finish_test();
        end
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        wait_resp(1'h1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        wait_resp(1'h0);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic poll(input logic [2:0] m);
        int n;
        n = 0;
        do begin
            axr(CMS_OFS_STATUS);
            n++;
        end while (rd[7:5] !== m && n < 20);
        chk("status_mode", 32'(rd[7:5]), 32'(m));
        chk("mode_status", 32'(mode_status), 32'(m));
    endtask
    task automatic irq_run(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            irq_req <= src[i];
            repeat (3) @(posedge aclk);
            axr(CMS_OFS_STATUS);
            chk("irq_code", rd, {24'h0, 3'h4, code[i]});
        end
        irq_req <= '0;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        axr(CMS_OFS_CONTROL);
        chk("control", rd, 32'h80);
        axr(CMS_OFS_ENH_CTRL);
        chk("enh_control", rd, 32'h10);
        note("reset");
        for (int w = 0; w < 8; w++) begin
            axw(CMS_OFS_CONTROL, 32'h81 | 32'(w * 2));
            chk("window_select", 32'(window_select), 32'(w));
            axr(CMS_OFS_CONTROL);
            chk("control", rd, 32'h80 | 32'(w * 2));
        end
        irq_run(0, 9);
        note("legacy");
        axw(CMS_OFS_ENH_CTRL, 32'h57);
        chk("mode_select", 32'(controller_mode_select), 32'h1);
        chk("enh_window", 32'(enhanced_window_select), 32'h17);
        axw(CMS_OFS_CONTROL, 32'h8f);
        axr(CMS_OFS_CONTROL);
        chk("control", rd, 32'h80);
        irq_run(10, 18);
        axw(CMS_OFS_ENH_CTRL, 32'h90);
        fifo_read_pointer <= 3'h5;
        axr(CMS_OFS_CONTROL);
        chk("control", rd, 32'h85);
        irq_run(19, 21);
        note("enhanced");
        axw(5'h10, 32'h0);
        chk("bresp", 32'(rs), 32'(CMS_RESP_SLVERR));
        axr(5'h10);
        chk("rresp", 32'(rs), 32'(CMS_RESP_SLVERR));
        axw(CMS_OFS_STATUS, 32'h1f);
        axr(CMS_OFS_STATUS);
        chk("status", rd, 32'h80);
        axw(CMS_OFS_ENH_CTRL, 32'h10);
        for (int m = 3; m >= 0; m--) begin
            axw(CMS_OFS_CONTROL, 32'(m * 32));
            poll(3'(m));
        end
        axw(CMS_OFS_ENH_CTRL, 32'h50);
        chk("mode_select", 32'(controller_mode_select), 32'h0);
        note("modes");
        frame_busy <= 1'h1;
        repeat (4) @(posedge aclk);
        for (int m = 4; m < 8; m++) begin
            axw(CMS_OFS_CONTROL, 32'(m * 32));
            repeat (8) @(posedge aclk);
            chk("mode_status", 32'(mode_status), 32'h0);
        end
        frame_busy <= 1'h0;
        poll(CMS_MODE_CONFIG);
        note("config");
        frame_busy <= 1'h1;
        tx_load <= 3'h7;
        @(posedge aclk);
        tx_load <= 3'h0;
        axw(CMS_OFS_CONTROL, 32'h90);
        chk("abort", 32'(abort_all_tx), 32'h1);
        repeat (4) @(posedge aclk);
        axr(CMS_OFS_CONTROL);
        chk("control", rd, 32'h90);
        // Frame still on the wire: all three pending, bus busy, abort held
        axr(CMS_OFS_EVENTS);
        chk("events", rd, 32'h1d);
        frame_busy <= 1'h0;
        for (int n = 0; n < 20 && abort_all_tx; n++)
            @(posedge aclk);
        chk("abort", 32'(abort_all_tx), 32'h0);
        chk("tx_pending", 32'(tx_pending), 32'h0);
        note("abort");
        // Park the controller in disable mode before the device sleeps
        axw(CMS_OFS_CONTROL, 32'h20);
        poll(CMS_MODE_DIS);
        note("sleep");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
